// file: core/lsadnr_luma_enh.sv
// luma sharpness, adaptive edge filter and noise coring with output skid buffer
`timescale 1ns/1ps
`default_nettype none
module lsadnr_luma_enh
  import lsadnr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // register port, serial interface side
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // incoming video
  input  wire logic       in_valid,
  input  wire lsa_pix_t   in_pix,
  output logic            in_ready,
  // processed video
  output logic            out_valid,
  output lsa_pix_t        out_pix,
  input  wire logic       out_ready
);

  // ------------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------------
  // pipeline at a glance:
  //   five-sample luma window, newest sample enters at [0]
  //   centre sample [2] is processed once the window holds three samples (fill at 2)
  //   result goes to a two-entry skid buffer towards out_pix
  //   every register, window and buffer lives in one struct
  // the window only moves on an accepted sample, so a stall
  // downstream freezes the whole pipe without losing a word
  // latency is two samples plus one clock in every mode,
  // which keeps luma in step with chroma and timing marks
  lsa_state_t s_r;   // all flops
  lsa_state_t s_nxt; // next value

  // products are kept at 16 bits: an 11-bit tap sum times a
  // 5-bit gain needs at most 16, so the cast never drops sign
  // signed product of a filter tap sum and a 5-bit gain
  function automatic logic signed [15:0] mulg(input logic signed [10:0] f,
                                              input logic signed [4:0]  g);
    mulg = 16'(f * g);
  endfunction

  // gain nibbles are two's complement, -8 to +7
  // signed nibble widened to 5 bits
  function automatic logic signed [4:0] snib(input logic [3:0] n);
    snib = $signed({n[3], n});
  endfunction

  // saturates rather than wraps, so strong boosts flatten out
  // unsigned clip to the luma range
  function automatic logic [7:0] clip8(input logic signed [15:0] v);
    if (v < 16'sd0) begin
      clip8 = 8'h00;
    end else if (v > 16'sd255) begin
      clip8 = LSA_LUMA_MAX;
    end else begin
      clip8 = v[7:0];
    end
  endfunction

  // ------------------------------------------------------------------
  // combinational datapath
  // ------------------------------------------------------------------
  logic              acc;                    // sample taken this cycle
  logic              push;                   // output word produced
  logic              pop;                    // head leaves
  lsa_pix_t [4:0]    w;                      // window after shift
  lsa_pix_t          res;                    // processed centre sample
  logic signed [10:0] fa;                    // filter a, narrow high pass
  logic signed [10:0] fb;                    // filter b, wide band
  logic signed [10:0] fab;                   // mean of a and b
  logic signed [10:0] der;                   // luma derivative
  logic [9:0]        dmag;                   // |derivative|
  logic [7:0]        gsel;                   // gain pair chosen by edge
  logic signed [4:0] ga;
  logic signed [4:0] gb;
  logic signed [15:0] hd_adj;
  logic signed [10:0] nf;                    // coring filter output
  logic [9:0]        nmag;
  logic [3:0]        ng;                     // coring gain in use
  logic signed [15:0] nd_adj;
  logic [3:0]        pidx;                   // centre pixel index
  logic [3:0]        lidx;                   // centre line index
  logic [3:0]        hpos;
  logic [3:0]        vpos;
  logic [4:0]        bsize;
  logic [4:0]        half;
  logic              on_border;
  logic              hd_sharp;
  logic              hd_adapt;

  // pushes follow accepted samples once the window holds a centre
  always_comb begin
    s_nxt    = s_r;
    acc      = in_valid && s_r.in_rdy;
    pop      = s_r.head_v && out_ready;
    push     = acc && (s_r.fill == 2'd2);
    w        = {s_r.win[3:0], in_pix};
    res      = w[2];
    hd_sharp = s_r.regs.sharp_en && !s_r.regs.adapt_en;
    hd_adapt = s_r.regs.sharp_en && s_r.regs.adapt_en;

    // --- filter taps on the window (same for every mode) ---
    // w[0] newest .. w[4] oldest, w[2] is the sample being processed
    // a: narrow three-tap high pass on the direct neighbours
    // b: wider high pass on the outer taps
    // all taps are computed every cycle whatever the mode, so the
    // latency never depends on the register settings
    fa   = 11'(($signed({3'b000, w[2].luma}) <<< 1) - $signed({3'b000, w[1].luma})
               - $signed({3'b000, w[3].luma}));
    fb   = 11'(($signed({3'b000, w[2].luma}) <<< 1) - $signed({3'b000, w[0].luma})
               - $signed({3'b000, w[4].luma}));
    fab  = 11'((fa + fb) >>> 1);
    der  = 11'($signed({3'b000, w[1].luma}) - $signed({3'b000, w[3].luma}));
    dmag = der[10] ? 10'(-der) : der[9:0];

    // --- adaptive: edge strength picks the gain pair ---
    // thresholds are compared in order a, b, c; software should keep
    // them rising, otherwise later bands are simply never reached
    // a quiet area keeps the sharpness gain, stronger edges take the
    // adaptive gains so ringing on them can be damped
    if (dmag < {2'b00, s_r.regs.athr_a}) begin
      gsel = s_r.regs.sharp_gain;
    end else if (dmag < {2'b00, s_r.regs.athr_b}) begin
      gsel = s_r.regs.again1;
    end else if (dmag < {2'b00, s_r.regs.athr_c}) begin
      gsel = s_r.regs.again2;
    end else begin
      gsel = s_r.regs.again3;
    end
    // low nibble gain a, high nibble gain b
    ga = snib(gsel[3:0]);
    gb = snib(gsel[7:4]);

    // --- high_def_path response ---
    // gains are in sixteenths: a gain of 7 adds 7/16 of the filter
    // output, a gain of -8 takes half of it away
    // with both enables clear the luma passes through unchanged
    if (hd_adapt && !s_r.regs.adapt_mode) begin
      // filter b path only, gain a not programmable
      hd_adj = (mulg(fb, gb) + mulg(fa, snib(LSA_FIXED_GAIN_A))) >>> 4;
    end else if (hd_adapt) begin
      hd_adj = (mulg(fa, ga) + mulg(fab, gb)) >>> 4;
    end else if (hd_sharp) begin
      // plain sharpness ignores edge strength
      hd_adj = (mulg(fa, snib(s_r.regs.sharp_gain[3:0]))
               + mulg(fb, snib(s_r.regs.sharp_gain[7:4]))) >>> 4;
    end else begin
      hd_adj = 16'sd0;
    end

    // --- noise coring input filter select ---
    // eight pass bands: the halved versions give a gentler coring
    // for the same threshold; the difference bands pick mid detail
    case (s_r.regs.nc2[2:0])
      3'd0:    nf = fa;
      3'd1:    nf = fb;
      3'd2:    nf = fab;
      3'd3:    nf = fa >>> 1;
      3'd4:    nf = fb >>> 1;
      3'd5:    nf = fab >>> 1;
      3'd6:    nf = 11'(fa - fb);
      default: nf = 11'((fa - fb) >>> 1);
    endcase
    nmag = nf[10] ? 10'(-nf) : nf[9:0];

    // --- block grid position of the centre sample ---
    // pixel index restarts at every line mark and the line index
    // at every frame mark; both use the centre sample's own marks
    // so the grid stays locked to the sample that is processed
    // counters are only four bits: larger positions wrap, which
    // matches the 16-pixel block as the biggest grid
    pidx = res.line_start ? 4'h0 : s_r.pix_cnt;
    if (res.frame_start) begin
      lidx = 4'h0;
    end else if (res.line_start) begin
      lidx = 4'(s_r.line_cnt + 4'h1);
    end else begin
      lidx = s_r.line_cnt;
    end
    // offset field shares bit 4 with the mode bit, as mapped
    hpos  = 4'(pidx + s_r.regs.nc2[7:4]);
    vpos  = 4'(lidx + s_r.regs.nc2[7:4]);
    bsize = s_r.regs.nc1[LSA_BLK16_BIT] ? 5'd16 : 5'd8;
    half  = s_r.regs.nc1[LSA_BORDER4_BIT] ? 5'd2 : 5'd1;
    if (!s_r.regs.nc1[LSA_BLK16_BIT]) begin
      hpos = {1'b0, hpos[2:0]};
      vpos = {1'b0, vpos[2:0]};
    end
    // a transition straddles the block edge, half each side
    on_border = ({1'b0, hpos} < half) || ({1'b0, hpos} >= 5'(bsize - half))
             || ({1'b0, vpos} < half) || ({1'b0, vpos} >= 5'(bsize - half));

    // border gain near block edges, data gain inside the block;
    // a gain above the ceiling is clamped rather than wrapped
    ng = on_border ? s_r.regs.nc0[3:0] : s_r.regs.nc0[7:4];
    if (!s_r.regs.nc2[LSA_NCMODE_BIT]) begin
      // coring: up to 8/8 of the noise removed
      if (ng > LSA_CORE_GMAX) begin
        ng = LSA_CORE_GMAX;
      end
      if (nmag < {4'h0, s_r.regs.nc1[5:0]}) begin
        nd_adj = -(mulg(nf, $signed({1'b0, ng})) >>> 3);
      end else begin
        nd_adj = 16'sd0;
      end
    end else begin
      // boost: up to 8/16 of valid detail added
      if (ng > LSA_BOOST_GMAX) begin
        ng = LSA_BOOST_GMAX;
      end
      if (nmag > {4'h0, s_r.regs.nc1[5:0]}) begin
        nd_adj = mulg(nf, $signed({1'b0, ng})) >>> 4;
      end else begin
        nd_adj = 16'sd0;
      end
    end

    // chroma and timing marks pass untouched
    if (w[2].sd_path) begin
      res.luma = clip8($signed({8'h00, w[2].luma}) + nd_adj);
    end else begin
      res.luma = clip8($signed({8'h00, w[2].luma}) + hd_adj);
    end

    // ------------------------------------------------------------------
    // window and grid counters advance only on accepted samples
    // ------------------------------------------------------------------
    if (acc) begin
      s_nxt.win = w;
      if (s_r.fill != 2'd2) begin
        s_nxt.fill = 2'(s_r.fill + 2'd1);
      end
    end
    if (push) begin
      s_nxt.pix_cnt  = 4'(pidx + 4'h1);
      s_nxt.line_cnt = lidx;
    end

    // ------------------------------------------------------------------
    // two-entry skid buffer: head drives the port, tail absorbs a stall
    // ------------------------------------------------------------------
    // the pop is applied first so a word can leave and another
    // enter in the same cycle; the tail is only used while the
    // head is stalled, and ready drops as soon as it fills
    if (pop) begin
      s_nxt.head   = s_r.tail;
      s_nxt.head_v = s_r.tail_v;
      s_nxt.tail_v = 1'b0;
    end
    if (push) begin
      if (!s_nxt.head_v) begin
        s_nxt.head   = res;
        s_nxt.head_v = 1'b1;
      end else begin
        s_nxt.tail   = res;
        s_nxt.tail_v = 1'b1;
      end
    end
    // ready registered: a free tail guarantees room for one push
    s_nxt.in_rdy = !s_nxt.tail_v;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // writes land at the edge that samples the strobe; spare bits of
    // the two control registers are dropped, unmapped addresses ignored
    if (reg_wr) begin
      case (reg_addr)
        LSA_SHARP_CTRL_ADDR: s_nxt.regs.sharp_en = reg_wdata[LSA_EN_BIT];
        LSA_ADAPT_CTRL_ADDR: begin
          s_nxt.regs.adapt_en   = reg_wdata[LSA_EN_BIT];
          s_nxt.regs.adapt_mode = reg_wdata[LSA_MODE_BIT];
        end
        LSA_SHARP_GAIN_ADDR: s_nxt.regs.sharp_gain = reg_wdata;
        LSA_AGAIN1_ADDR:     s_nxt.regs.again1     = reg_wdata;
        LSA_AGAIN2_ADDR:     s_nxt.regs.again2     = reg_wdata;
        LSA_AGAIN3_ADDR:     s_nxt.regs.again3     = reg_wdata;
        LSA_ATHR_A_ADDR:     s_nxt.regs.athr_a     = reg_wdata;
        LSA_ATHR_B_ADDR:     s_nxt.regs.athr_b     = reg_wdata;
        LSA_ATHR_C_ADDR:     s_nxt.regs.athr_c     = reg_wdata;
        LSA_NC0_ADDR:        s_nxt.regs.nc0        = reg_wdata;
        LSA_NC1_ADDR:        s_nxt.regs.nc1        = reg_wdata;
        LSA_NC2_ADDR:        s_nxt.regs.nc2        = reg_wdata;
        default: ; // other subaddresses belong elsewhere
      endcase
    end

    // ------------------------------------------------------------------
    // register reads: one cycle later, unmapped reads give zero
    // ------------------------------------------------------------------
    // read data is taken from the registers before any write of the
    // same cycle, and holds until the next read
    s_nxt.rd_valid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        LSA_SHARP_CTRL_ADDR: s_nxt.rd_data = {s_r.regs.sharp_en, 7'h00};
        LSA_ADAPT_CTRL_ADDR: s_nxt.rd_data = {s_r.regs.adapt_en, s_r.regs.adapt_mode, 6'h00};
        LSA_SHARP_GAIN_ADDR: s_nxt.rd_data = s_r.regs.sharp_gain;
        LSA_AGAIN1_ADDR:     s_nxt.rd_data = s_r.regs.again1;
        LSA_AGAIN2_ADDR:     s_nxt.rd_data = s_r.regs.again2;
        LSA_AGAIN3_ADDR:     s_nxt.rd_data = s_r.regs.again3;
        LSA_ATHR_A_ADDR:     s_nxt.rd_data = s_r.regs.athr_a;
        LSA_ATHR_B_ADDR:     s_nxt.rd_data = s_r.regs.athr_b;
        LSA_ATHR_C_ADDR:     s_nxt.rd_data = s_r.regs.athr_c;
        LSA_NC0_ADDR:        s_nxt.rd_data = s_r.regs.nc0;
        LSA_NC1_ADDR:        s_nxt.rd_data = s_r.regs.nc1;
        LSA_NC2_ADDR:        s_nxt.rd_data = s_r.regs.nc2;
        default:             s_nxt.rd_data = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register, synchronous reset
  // ------------------------------------------------------------------
  // reset clears every control, so all filtering is off and the
  // luma passes through until software enables a mode
  // ready comes up with reset: an empty buffer can always take a word
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r                 <= '0;
      s_r.regs.sharp_gain <= LSA_REG_RST;
      s_r.in_rdy          <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs straight from flops
  // ------------------------------------------------------------------
  // every port below is a plain flop output, no logic after the
  // registers, so downstream timing sees a clean clock-to-out
  assign in_ready   = s_r.in_rdy;
  assign out_valid  = s_r.head_v;
  assign out_pix    = s_r.head;
  assign reg_rdata  = s_r.rd_data;
  assign reg_rvalid = s_r.rd_valid;

endmodule
`default_nettype wire

// file: core/lsadnr_pkg.sv
// package: constants, register map and carrier types of the luma sharpness / noise coring block
package lsadnr_pkg;
  // ------------------------------------------------------------------
  // register subaddresses
  // ------------------------------------------------------------------
  localparam logic [7:0] LSA_SHARP_CTRL_ADDR = 8'h31; // sharpness enable, bit 7
  localparam logic [7:0] LSA_ADAPT_CTRL_ADDR = 8'h35; // adaptive enable bit 7, mode bit 6
  localparam logic [7:0] LSA_SHARP_GAIN_ADDR = 8'h40;
  localparam logic [7:0] LSA_AGAIN1_ADDR     = 8'h58;
  localparam logic [7:0] LSA_AGAIN2_ADDR     = 8'h59;
  localparam logic [7:0] LSA_AGAIN3_ADDR     = 8'h5A;
  localparam logic [7:0] LSA_ATHR_A_ADDR     = 8'h5B;
  localparam logic [7:0] LSA_ATHR_B_ADDR     = 8'h5C;
  localparam logic [7:0] LSA_ATHR_C_ADDR     = 8'h5D;
  localparam logic [7:0] LSA_NC0_ADDR        = 8'hA3;
  localparam logic [7:0] LSA_NC1_ADDR        = 8'hA4;
  localparam logic [7:0] LSA_NC2_ADDR        = 8'hA5;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int LSA_EN_BIT        = 7; // enable bit in 0x31 and 0x35
  localparam int LSA_MODE_BIT      = 6; // adaptive mode select in 0x35
  localparam int LSA_BLK16_BIT     = 7; // nc1 block size
  localparam int LSA_BORDER4_BIT   = 6; // nc1 border width
  localparam int LSA_NCMODE_BIT    = 4; // nc2 coring / boost
  // ------------------------------------------------------------------
  // reset values and fixed numbers
  // ------------------------------------------------------------------
  localparam logic [7:0] LSA_REG_RST      = 8'h00;
  localparam logic [3:0] LSA_FIXED_GAIN_A = 4'h0; // gain a held in adaptive mode a
  localparam logic [3:0] LSA_CORE_GMAX    = 4'h8; // coring gain ceiling, 8/8
  localparam logic [3:0] LSA_BOOST_GMAX   = 4'h8; // boost gain ceiling, 8/16
  localparam logic [7:0] LSA_LUMA_MAX     = 8'hFF;

  // one video sample with its timing marks
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
    logic       sd_path;     // 1: standard_def_path, 0: high_def_path
    logic       line_start;
    logic       frame_start;
  } lsa_pix_t;

  // software-visible controls
  typedef struct packed {
    logic       sharp_en;
    logic       adapt_en;
    logic       adapt_mode;
    logic [7:0] sharp_gain;
    logic [7:0] again1;
    logic [7:0] again2;
    logic [7:0] again3;
    logic [7:0] athr_a;
    logic [7:0] athr_b;
    logic [7:0] athr_c;
    logic [7:0] nc0;
    logic [7:0] nc1;
    logic [7:0] nc2;
  } lsa_regs_t;

  // whole state of the block
  typedef struct packed {
    lsa_regs_t          regs;
    lsa_pix_t [4:0]     win;      // luma window, [0] newest
    logic [1:0]         fill;     // samples held, saturates at 2
    logic [3:0]         pix_cnt;  // next pixel index in line
    logic [3:0]         line_cnt; // current line index in frame
    lsa_pix_t           head;
    lsa_pix_t           tail;
    logic               head_v;
    logic               tail_v;
    logic               in_rdy;
    logic [7:0]         rd_data;
    logic               rd_valid;
  } lsa_state_t;
endpackage

// file: testbench/lsadnr_luma_enh_sva.sv
// checker: port-level properties of the luma enhancement block
`timescale 1ns/1ps
`default_nettype none
module lsadnr_luma_enh_sva
  import lsadnr_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       in_valid,
  input wire lsa_pix_t   in_pix,
  input wire logic       in_ready,
  input wire logic       out_valid,
  input wire lsa_pix_t   out_pix,
  input wire logic       out_ready
);
  // ----------------------------------------------------------------
  // one clock domain, reset masks everything but the reset check
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_sharp_ctrl_bits;
    reg_rd && reg_addr == 8'h31 |=> reg_rdata[6:0] == 7'h00;
  endproperty
  a_sharp_ctrl_bits: assert property (p_sharp_ctrl_bits) else $error("0x31 spare bits");
  property p_adapt_ctrl_bits;
    reg_rd && reg_addr == 8'h35 |=> reg_rdata[5:0] == 6'h00;
  endproperty
  a_adapt_ctrl_bits: assert property (p_adapt_ctrl_bits) else $error("0x35 spare bits");
  property p_gain_readback;
    reg_wr && reg_addr == 8'h40 ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 8'h40
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_gain_readback: assert property (p_gain_readback) else $error("gain readback");
  // a held output word may not change or vanish while stalled
  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_pix);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped");
  property p_rise_cause;
    $rose(out_valid) |-> $past(in_valid && in_ready);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("output without input");
  property p_ready_stays_low;
    !in_ready && !(out_valid && out_ready) |=> !in_ready;
  endproperty
  a_ready_stays_low: assert property (p_ready_stays_low) else $error("ready without pop");
  property p_reset_state;
    disable iff (1'b0) reset |=> in_ready && !out_valid && !reg_rvalid;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state");
endmodule
bind lsadnr_luma_enh lsadnr_luma_enh_sva u_sva (.sys_clk(sys_clk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .in_valid(in_valid), .in_pix(in_pix),
  .in_ready(in_ready), .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready));
`default_nettype wire

// file: testbench/lsadnr_luma_enh_tb_top.sv
// testbench: register port and video stream checks of the luma block
`timescale 1ns/1ps
`default_nettype none
`define LSA_CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module lsadnr_luma_enh_tb_top;
  import lsadnr_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       in_valid;
  lsa_pix_t   in_pix;
  logic       in_ready;
  logic       out_valid;
  lsa_pix_t   out_pix;
  logic       out_ready = 1'b1;
  int         n_fail = 0;
  int         comparisons = 0;
  int         n_sent = 0;
  int         n_out = 0;
  logic [7:0] out_luma [0:255]; // luma seen, by sample index
  logic [7:0] rd;
  logic [7:0] amap [12] = '{8'h31, 8'h35, 8'h40, 8'h58, 8'h59, 8'h5A,
                            8'h5B, 8'h5C, 8'h5D, 8'hA3, 8'hA4, 8'hA5};

  always #2.5 sys_clk = ~sys_clk; // 200 MHz

  lsadnr_luma_enh uut (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .in_valid(in_valid), .in_pix(in_pix), .in_ready(in_ready),
    .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready));
  lsadnr_src_model src (.sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_pix(in_pix));

  // ----------------------------------------------------------------
  // output monitor: order and chroma must survive any stall
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset && out_valid === 1'b1 && out_ready) begin
      `LSA_CHK("chroma", n_out[7:0], out_pix.chroma)
      `LSA_CHK("line mark", n_out % 12 == 0, out_pix.line_start)
      `LSA_CHK("frame mark", n_out % 12 == 0, out_pix.frame_start)
      `LSA_CHK("path flag", n_out >= 84, out_pix.sd_path)
      out_luma[n_out[7:0]] = out_pix.luma;
      n_out++;
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // answer is registered, read just after the edge that raised it
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `LSA_CHK("read valid", 1'b1, reg_rvalid)
    d = reg_rdata;
  endtask

  // twelve samples, flat 100 with a 120 spike at index 5
  task automatic run(input logic sd, input logic stall, input logic [7:0] exp_l);
    int       base;
    int       k;
    bit       ok;
    lsa_pix_t p;
    base = n_sent;
    if (stall) out_ready <= 1'b0;
    fork
      begin
        for (k = 0; k < 12; k++) begin
          p = '{luma: (k == 5) ? 8'd120 : 8'd100, chroma: n_sent[7:0], sd_path: sd,
                line_start: (k == 0), frame_start: (k == 0)};
          src.send(p, k % 3 == 2 ? 2 : 0, ok);
          `LSA_CHK("input taken", 1'b1, ok)
          if (!ok) report_and_stop();
          n_sent++;
        end
        src.idle();
      end
      if (stall) begin
        repeat (12) @(posedge sys_clk);
        `LSA_CHK("in_ready stalled", 1'b0, in_ready)
        out_ready <= 1'b1;
      end
    join
    for (k = 0; k < 100 && n_out < n_sent - 2; k++) @(posedge sys_clk);
    `LSA_CHK("outputs drained", 1'b1, n_out >= n_sent - 2)
    if (n_out < n_sent - 2) report_and_stop();
    `LSA_CHK("spike luma", exp_l, out_luma[base + 5])
    `LSA_CHK("flat luma", 8'd100, out_luma[base + 9])
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      reg_read(amap[i], rd);
      `LSA_CHK("reset value", 8'h00, rd)
    end
    for (int i = 2; i < 12; i++) begin
      reg_write(amap[i], amap[i] ^ 8'h5A);
      reg_read(amap[i], rd);
      `LSA_CHK("readback", amap[i] ^ 8'h5A, rd)
    end
    reg_write(8'h31, 8'hFF);
    reg_read(8'h31, rd);
    `LSA_CHK("sharp ctrl", 8'h80, rd)
    reg_write(8'h35, 8'hFF);
    reg_read(8'h35, rd);
    `LSA_CHK("adapt ctrl", 8'hC0, rd)
    reg_write(8'h00, 8'hFF);
    reg_read(8'h00, rd);
    `LSA_CHK("unmapped", 8'h00, rd)
    // back to a clean state before video
    for (int i = 0; i < 12; i++) reg_write(amap[i], 8'h00);
    run(1'b0, 1'b0, 8'd120);
    reg_write(8'h40, 8'h22);
    run(1'b0, 1'b0, 8'd120);
    reg_write(8'h31, 8'h80);
    run(1'b0, 1'b1, 8'd130);
    reg_write(8'h35, 8'h80);
    reg_write(8'h40, 8'h2F);
    reg_write(8'h5B, 8'h28);
    run(1'b0, 1'b0, 8'd125);
    reg_write(8'h5B, 8'h00);
    reg_write(8'h5C, 8'h28);
    reg_write(8'h58, 8'h4F);
    run(1'b0, 1'b0, 8'd130);
    reg_write(8'h35, 8'hC0);
    run(1'b0, 1'b0, 8'd127);
    reg_write(8'h31, 8'h00);
    run(1'b0, 1'b0, 8'd120);
    reg_write(8'hA3, 8'h88);
    reg_write(8'hA4, 8'h32);
    run(1'b1, 1'b0, 8'd80);
    reg_write(8'hA4, 8'h28);
    run(1'b1, 1'b0, 8'd120);
    // border gain halved: offset 1 keeps the spike inside the block
    reg_write(8'hA3, 8'h84);
    reg_write(8'hA5, 8'h10);
    reg_write(8'hA4, 8'h14);
    run(1'b1, 1'b1, 8'd140);
    reg_write(8'hA5, 8'h30);
    reg_write(8'hA4, 8'h94);
    run(1'b1, 1'b0, 8'd140);
    reg_write(8'hA5, 8'h10);
    reg_write(8'hA4, 8'hD4);
    run(1'b1, 1'b0, 8'd130);
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: testbench/lsadnr_src_model.sv
// upstream video source model: offers samples under valid/ready
`timescale 1ns/1ps
`default_nettype none
module lsadnr_src_model
  import lsadnr_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     in_ready,
  output var  logic     in_valid,
  output var  lsa_pix_t in_pix
);
  initial begin
    in_valid = 1'b0;
    in_pix   = '0;
  end
  // called just after an edge; holds the sample until taken
  task automatic send(input lsa_pix_t p, input int gap, output bit ok);
    int n;
    // a gap drops valid, so the last sample is not offered twice
    if (gap > 0) begin
      in_valid <= 1'b0;
      repeat (gap) @(posedge sys_clk); // slow source
    end
    in_valid <= 1'b1; // at most one sample per clock
    in_pix   <= p;
    ok = 1'b0;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge sys_clk);
      ok = in_ready; // value the block sampled at this edge
    end
  endtask
  // released bus shows the inverse, not the stale sample
  task automatic idle();
    in_valid <= 1'b0;
    in_pix   <= lsa_pix_t'(~in_pix);
  endtask
endmodule
`default_nettype wire
